// ### src/chi_pkg.sv
package chi_pkg;
	// ****************
	// Timing
	// ****************
	localparam int SYS_CLK_MHZ = 20;
	localparam int INT_PULSE_US = 256;
	localparam int INT_PULSE_CYC = INT_PULSE_US * SYS_CLK_MHZ;
	localparam int I2C_FAST_KHZ = 400;
	localparam int SCL_QUARTER_CYC = (SYS_CLK_MHZ * 1000 + 4 * I2C_FAST_KHZ - 1) / (4 * I2C_FAST_KHZ);
	// ****************
	// Register map
	// ****************
	localparam logic [6:0] SLAVE_ADDR = 7'h6b;
	localparam logic [7:0] REG_CTRL1 = 8'h01;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_FAULT = 8'h09;
	localparam logic [7:0] REG_MASK = 8'h0a;
	localparam logic [7:0] LAST_REGISTER = 8'h0b;
	localparam logic [7:0] READ_BEYOND = 8'hff;
	localparam int REG_COUNT = 12;
	localparam logic [7:0] REG_RST [0:11] = '{8'h17, 8'h1a, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam int BOOST_EN_BIT = 5;
	localparam int THERMAL_LOOP_STATUS_BIT = 1;
	localparam int MASK_VLIM_BIT = 1;
	localparam int MASK_ILIM_BIT = 0;
	localparam logic [2:0] BOOST_RETRIES = 3'h7;
	// ****************
	// Fault register fields
	// ****************
	localparam int FLT_BOOST_BIT = 6;
	localparam int FLT_CHG_LSB = 4;
	localparam int FLT_BATTERY_OVERVOLTAGE_EVENT_BIT = 3;
	localparam logic [1:0] CHG_CODE_NONE = 2'h0;
	localparam logic [1:0] CHG_CODE_INOV = 2'h1;
	localparam logic [1:0] CHG_CODE_TSHUT = 2'h2;
	localparam logic [1:0] CHG_CODE_TIMER = 2'h3;
	// ****************
	// State machines
	// ****************
	typedef enum logic [6:0] {
		SL_IDLE = 7'h01,
		SL_ADDR = 7'h02,
		SL_PTR = 7'h04,
		SL_WR = 7'h08,
		SL_ACK = 7'h10,
		SL_RD = 7'h20,
		SL_MACK = 7'h40
	} chi_slv_state_e;
	typedef enum logic [3:0] {
		HS_IDLE = 4'h1,
		HS_START = 4'h2,
		HS_BIT = 4'h4,
		HS_STOP = 4'h8
	} chi_hst_state_e;
endpackage : chi_pkg

// ### src/chi_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface chi_link_if;
	logic scl_host_out;
	logic scl_host_oe;
	logic sda_host_out;
	logic sda_host_oe;
	logic scl_dev_out;
	logic scl_dev_oe;
	logic sda_dev_out;
	logic sda_dev_oe;
	logic scl;
	logic sda;
	// Wired-AND of the open-drain drivers with a pull-up
	assign scl = (scl_host_oe ? scl_host_out : 1'b1) & (scl_dev_oe ? scl_dev_out : 1'b1);
	assign sda = (sda_host_oe ? sda_host_out : 1'b1) & (sda_dev_oe ? sda_dev_out : 1'b1);
	modport dev (input scl, input sda, output scl_dev_out, output scl_dev_oe,
		output sda_dev_out, output sda_dev_oe);
	modport host (input scl, input sda, output scl_host_out, output scl_host_oe,
		output sda_host_out, output sda_host_oe);
endinterface : chi_link_if
`default_nettype wire

// ### src/chi_sync.sv
`timescale 1ns/1ns
`default_nettype none
module chi_sync #(
	parameter int W = 2
) (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_reg <= '1;
			q_out <= '1;
		end else begin
			meta_reg <= d_in;
			q_out <= meta_reg;
		end
	end
endmodule : chi_sync
`default_nettype wire

// ### src/chi_device.sv
`timescale 1ns/1ns
`default_nettype none
module chi_device #(
	parameter int INT_PULSE_CYCLES = chi_pkg::INT_PULSE_CYC
) (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	chi_link_if.dev link,
	input wire logic src_ident_in,
	input wire logic good_src_in,
	input wire logic src_removed_in,
	input wire logic src_plug_in,
	input wire logic chg_done_in,
	input wire logic input_voltage_limit_loop_in,
	input wire logic input_current_limit_loop_in,
	input wire logic input_overvoltage_event_in,
	input wire logic system_overvoltage_event_in,
	input wire logic boost_short_in,
	input wire logic boost_ov_in,
	input wire logic temp_reg_in,
	input wire logic temp_shut_in,
	input wire logic battery_overvoltage_event_in,
	input wire logic batt_depleted_in,
	input wire logic batt_oc_in,
	input wire logic ship_exit_in,
	input wire logic timer_expired_in,
	input wire logic [2:0] thermistor_fault_field_in,
	output logic int_n_out,
	output logic switching_en_out,
	output logic charge_en_out,
	output logic boost_run_out,
	output logic battery_switch_on_out,
	output logic current_reduce_out,
	output logic term_en_out,
	output logic timer_half_rate_out
);
	// ****************
	// Link sampling
	// ****************
	logic scl_s;
	logic sda_s;
	logic scl_d_reg;
	logic sda_d_reg;
	chi_sync #(.W(2)) u_sync (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.d_in({link.scl, link.sda}),
		.q_out({scl_s, sda_s})
	);
	wire scl_rise = scl_s & ~scl_d_reg;
	wire scl_fall = ~scl_s & scl_d_reg;
	wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	// ****************
	// Slave engine
	// ****************
	chi_pkg::chi_slv_state_e state_reg;
	chi_pkg::chi_slv_state_e state_next;
	chi_pkg::chi_slv_state_e ack_to_reg;
	chi_pkg::chi_slv_state_e ack_to_next;
	logic [3:0] bitcnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic [7:0] ptr_reg;
	logic mack_reg;
	logic sda_oe_reg;
	logic sda_oe_next;
	logic [7:0] regs_reg [0:chi_pkg::REG_COUNT-1];
	logic [7:0] fault_latch_reg;
	logic [7:0] rd_data;

	wire receiving = (state_reg == chi_pkg::SL_ADDR) | (state_reg == chi_pkg::SL_PTR)
		| (state_reg == chi_pkg::SL_WR);
	wire byte_end = scl_fall & (bitcnt_reg == 4'h8);
	wire addr_hit = shift_reg[7:1] == chi_pkg::SLAVE_ADDR;
	wire ptr_ok = shift_reg <= chi_pkg::LAST_REGISTER;
	wire cur_ok = ptr_reg <= chi_pkg::LAST_REGISTER;
	wire load_tx = scl_fall & (((state_reg == chi_pkg::SL_ACK) & (ack_to_reg == chi_pkg::SL_RD))
		| ((state_reg == chi_pkg::SL_MACK) & mack_reg));
	wire [7:0] ptr_inc = (ptr_reg == chi_pkg::REG_FAULT) ? ptr_reg : 8'(ptr_reg + 8'h01);
	wire wr_strobe = (state_reg == chi_pkg::SL_WR) & byte_end & cur_ok
		& (ptr_reg != chi_pkg::REG_FAULT) & (ptr_reg != chi_pkg::REG_STATUS);
	wire fault_read = load_tx & (ptr_reg == chi_pkg::REG_FAULT);
	wire [7:0] status_w = 8'(temp_reg_in) << chi_pkg::THERMAL_LOOP_STATUS_BIT;
	wire [7:0] fault_rd = {fault_latch_reg[7:3], thermistor_fault_field_in};

	// Read data selection
	always_comb begin
		if (!cur_ok)
			rd_data = chi_pkg::READ_BEYOND;
		else if (ptr_reg == chi_pkg::REG_FAULT)
			rd_data = fault_rd;
		else if (ptr_reg == chi_pkg::REG_STATUS)
			rd_data = status_w;
		else
			rd_data = regs_reg[ptr_reg[3:0]];
	end

	always_comb begin
		state_next = state_reg;
		ack_to_next = ack_to_reg;
		sda_oe_next = sda_oe_reg;
		if (start_det) begin
			state_next = chi_pkg::SL_ADDR;
			sda_oe_next = 1'b0;
		end else if (stop_det) begin
			state_next = chi_pkg::SL_IDLE;
			sda_oe_next = 1'b0;
		end else if (scl_fall) begin
			case (state_reg)
				chi_pkg::SL_ADDR: begin
					if (byte_end && addr_hit) begin
						state_next = chi_pkg::SL_ACK;
						sda_oe_next = 1'b1;
						ack_to_next = shift_reg[0] ? chi_pkg::SL_RD : chi_pkg::SL_PTR;
					end else if (byte_end) begin
						state_next = chi_pkg::SL_IDLE;
					end
				end
				chi_pkg::SL_PTR: begin
					if (byte_end && ptr_ok) begin
						state_next = chi_pkg::SL_ACK;
						sda_oe_next = 1'b1;
						ack_to_next = chi_pkg::SL_WR;
					end else if (byte_end) begin
						state_next = chi_pkg::SL_IDLE;
					end
				end
				chi_pkg::SL_WR: begin
					if (byte_end) begin
						state_next = cur_ok ? chi_pkg::SL_ACK : chi_pkg::SL_IDLE;
						sda_oe_next = cur_ok;
					end
				end
				chi_pkg::SL_ACK: begin
					state_next = ack_to_reg;
					sda_oe_next = (ack_to_reg == chi_pkg::SL_RD) & ~rd_data[7];
				end
				chi_pkg::SL_RD: begin
					state_next = byte_end ? chi_pkg::SL_MACK : chi_pkg::SL_RD;
					sda_oe_next = ~byte_end & ~tx_reg[6];
				end
				chi_pkg::SL_MACK: begin
					state_next = mack_reg ? chi_pkg::SL_RD : chi_pkg::SL_IDLE;
					sda_oe_next = mack_reg & ~rd_data[7];
				end
				default: begin
					state_next = chi_pkg::SL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= chi_pkg::SL_IDLE;
			ack_to_reg <= chi_pkg::SL_IDLE;
			sda_oe_reg <= 1'b0;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			ack_to_reg <= ack_to_next;
			sda_oe_reg <= sda_oe_next;
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bitcnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			mack_reg <= 1'b0;
		end else begin
			if (start_det || byte_end)
				bitcnt_reg <= 4'h0;
			else if (scl_rise && (receiving || state_reg == chi_pkg::SL_RD))
				bitcnt_reg <= 4'(bitcnt_reg + 4'h1);
			if (scl_rise && receiving)
				shift_reg <= {shift_reg[6:0], sda_s};
			if (load_tx)
				tx_reg <= rd_data;
			else if (scl_fall && state_reg == chi_pkg::SL_RD)
				tx_reg <= {tx_reg[6:0], 1'b1};
			if (state_reg == chi_pkg::SL_PTR && byte_end && ptr_ok)
				ptr_reg <= shift_reg;
			else if (wr_strobe || load_tx)
				ptr_reg <= ptr_inc;
			if (scl_rise && state_reg == chi_pkg::SL_MACK)
				mack_reg <= ~sda_s;
		end
	end

	// ****************
	// Registers and protection
	// ****************
	logic [2:0] retry_reg;
	logic boost_fault_reg;
	logic dpl_latch_reg;
	logic oc_latch_reg;
	logic vlim_d_reg;
	logic ilim_d_reg;
	logic [12:0] int_cnt_reg;
	wire boost_en = regs_reg[chi_pkg::REG_CTRL1[3:0]][chi_pkg::BOOST_EN_BIT];
	wire host_ctrl1_wr = wr_strobe & (ptr_reg == chi_pkg::REG_CTRL1);
	wire retries_spent = boost_short_in & (retry_reg == chi_pkg::BOOST_RETRIES);
	wire boost_kill = retries_spent | boost_ov_in | temp_shut_in;
	wire [1:0] chg_code = temp_shut_in ? chi_pkg::CHG_CODE_TSHUT
		: input_overvoltage_event_in ? chi_pkg::CHG_CODE_INOV
		: timer_expired_in ? chi_pkg::CHG_CODE_TIMER
		: chi_pkg::CHG_CODE_NONE;
	wire [7:0] fault_live = (8'(boost_fault_reg) << chi_pkg::FLT_BOOST_BIT)
		| (8'(chg_code) << chi_pkg::FLT_CHG_LSB)
		| (8'(battery_overvoltage_event_in) << chi_pkg::FLT_BATTERY_OVERVOLTAGE_EVENT_BIT);
	wire fault_new = (fault_latch_reg == 8'h00) & (fault_live != 8'h00);
	wire [7:0] mask_w = regs_reg[chi_pkg::REG_MASK[3:0]];
	wire vlim_evt = input_voltage_limit_loop_in & ~vlim_d_reg & ~mask_w[chi_pkg::MASK_VLIM_BIT];
	wire ilim_evt = input_current_limit_loop_in & ~ilim_d_reg & ~mask_w[chi_pkg::MASK_ILIM_BIT];
	wire int_evt = src_ident_in | good_src_in | src_removed_in | chg_done_in
		| fault_new | vlim_evt | ilim_evt;
	wire [12:0] int_cnt_next = int_evt ? 13'(INT_PULSE_CYCLES)
		: (int_cnt_reg != 13'h0000) ? 13'(int_cnt_reg - 13'h0001) : 13'h0000;

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < chi_pkg::REG_COUNT; i++)
				regs_reg[i] <= chi_pkg::REG_RST[i];
		end else begin
			if (wr_strobe)
				regs_reg[ptr_reg[3:0]] <= shift_reg;
			if (boost_kill)
				regs_reg[chi_pkg::REG_CTRL1[3:0]][chi_pkg::BOOST_EN_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			retry_reg <= 3'h0;
			boost_fault_reg <= 1'b0;
			fault_latch_reg <= 8'h00;
			dpl_latch_reg <= 1'b0;
			oc_latch_reg <= 1'b0;
			vlim_d_reg <= 1'b0;
			ilim_d_reg <= 1'b0;
			int_cnt_reg <= 13'h0000;
		end else begin
			if (host_ctrl1_wr || retries_spent)
				retry_reg <= 3'h0;
			else if (boost_short_in)
				retry_reg <= 3'(retry_reg + 3'h1);
			if (retries_spent || boost_ov_in)
				boost_fault_reg <= 1'b1;
			else if (host_ctrl1_wr && shift_reg[chi_pkg::BOOST_EN_BIT])
				boost_fault_reg <= 1'b0;
			if (fault_read)
				fault_latch_reg <= fault_live;
			else if (fault_new)
				fault_latch_reg <= fault_live;
			if (batt_depleted_in)
				dpl_latch_reg <= 1'b1;
			else if (src_plug_in)
				dpl_latch_reg <= 1'b0;
			if (batt_oc_in)
				oc_latch_reg <= 1'b1;
			else if (ship_exit_in)
				oc_latch_reg <= 1'b0;
			vlim_d_reg <= input_voltage_limit_loop_in;
			ilim_d_reg <= input_current_limit_loop_in;
			int_cnt_reg <= int_cnt_next;
		end
	end

	// ****************
	// Outputs
	// ****************
	wire sw_stop = input_overvoltage_event_in | system_overvoltage_event_in
		| temp_shut_in | boost_ov_in;
	wire chg_stop = battery_overvoltage_event_in | temp_shut_in | input_overvoltage_event_in;
	wire boost_next = boost_en & ~boost_kill & ~boost_short_in;
	wire bsw_next = ~(dpl_latch_reg | oc_latch_reg | temp_shut_in);

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			int_n_out <= 1'b1;
			switching_en_out <= 1'b0;
			charge_en_out <= 1'b0;
			boost_run_out <= 1'b0;
			battery_switch_on_out <= 1'b0;
			current_reduce_out <= 1'b0;
			term_en_out <= 1'b0;
			timer_half_rate_out <= 1'b0;
		end else begin
			int_n_out <= int_cnt_next == 13'h0000;
			switching_en_out <= ~sw_stop;
			charge_en_out <= ~chg_stop;
			boost_run_out <= boost_next;
			battery_switch_on_out <= bsw_next;
			current_reduce_out <= temp_reg_in;
			term_en_out <= ~temp_reg_in;
			timer_half_rate_out <= temp_reg_in;
		end
	end

	assign link.sda_dev_out = 1'b0;
	assign link.sda_dev_oe = sda_oe_reg;
	assign link.scl_dev_out = 1'b0;
	assign link.scl_dev_oe = 1'b0;
endmodule : chi_device
`default_nettype wire

// ### src/chi_host.sv
`timescale 1ns/1ns
`default_nettype none
module chi_host (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	chi_link_if.host link,
	input wire logic cmd_valid_in,
	input wire logic cmd_read_in,
	input wire logic [7:0] cmd_ptr_in,
	input wire logic [7:0] cmd_wdata_in,
	output logic cmd_ready_out,
	output logic rsp_valid_out,
	output logic rsp_ack_out,
	output logic [7:0] rsp_data_out
);
	logic scl_s;
	logic sda_s;
	chi_sync #(.W(2)) u_sync (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.d_in({link.scl, link.sda}),
		.q_out({scl_s, sda_s})
	);

	chi_pkg::chi_hst_state_e state_reg;
	logic [1:0] ph_reg;
	logic [3:0] tmr_reg;
	logic [2:0] step_reg;
	logic [3:0] bit_reg;
	logic [7:0] tx_reg;
	logic [7:0] rx_reg;
	logic rd_op_reg;
	logic ok_reg;
	logic [7:0] ptr_reg;
	logic [7:0] wdata_reg;
	logic scl_oe_reg;
	logic sda_oe_reg;

	localparam logic [3:0] QUARTER = 4'(chi_pkg::SCL_QUARTER_CYC - 1);
	wire tick = (tmr_reg == 4'h0) & ((ph_reg != 2'h2) | scl_s);
	wire last_bit = bit_reg == 4'h8;
	wire acked = ok_reg;
	wire [2:0] step_inc = 3'(step_reg + 3'h1);
	wire restart = (step_reg == 3'h1) & rd_op_reg;
	wire byte_over = (state_reg == chi_pkg::HS_BIT) & tick & (ph_reg == 2'h3) & last_bit;
	wire go_stop = byte_over & (~acked | (step_reg == 3'h4) | (step_reg == 3'h2));
	logic [7:0] tx_sel;

	// Byte sent in each step of a transfer after the first address byte
	always_comb begin
		case (step_inc)
			3'h1: tx_sel = ptr_reg;
			3'h2: tx_sel = wdata_reg;
			3'h3: tx_sel = {chi_pkg::SLAVE_ADDR, 1'b1};
			default: tx_sel = 8'hff;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			tmr_reg <= 4'h0;
		else if (state_reg == chi_pkg::HS_IDLE || tick)
			tmr_reg <= QUARTER;
		else if (tmr_reg != 4'h0)
			tmr_reg <= 4'(tmr_reg - 4'h1);
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= chi_pkg::HS_IDLE;
			ph_reg <= 2'h0;
			step_reg <= 3'h0;
			bit_reg <= 4'h0;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			rd_op_reg <= 1'b0;
			ok_reg <= 1'b0;
			ptr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			cmd_ready_out <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_ack_out <= 1'b0;
			rsp_data_out <= 8'h00;
		end else begin
			rsp_valid_out <= 1'b0;
			case (state_reg)
				chi_pkg::HS_IDLE: begin
					cmd_ready_out <= ~(cmd_valid_in & cmd_ready_out);
					if (cmd_valid_in && cmd_ready_out) begin
						state_reg <= chi_pkg::HS_START;
						rd_op_reg <= cmd_read_in;
						ptr_reg <= cmd_ptr_in;
						wdata_reg <= cmd_wdata_in;
						step_reg <= 3'h0;
						tx_reg <= {chi_pkg::SLAVE_ADDR, 1'b0};
					end
					ph_reg <= 2'h0;
				end
				chi_pkg::HS_START: begin
					if (tick) begin
						ph_reg <= 2'(ph_reg + 2'h1);
						case (ph_reg)
							2'h0: sda_oe_reg <= 1'b0;
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: sda_oe_reg <= 1'b1;
							default: begin
								scl_oe_reg <= 1'b1;
								state_reg <= chi_pkg::HS_BIT;
								bit_reg <= 4'h0;
							end
						endcase
					end
				end
				chi_pkg::HS_BIT: begin
					if (tick) begin
						ph_reg <= 2'(ph_reg + 2'h1);
						case (ph_reg)
							2'h0: sda_oe_reg <= ~last_bit & ~tx_reg[7];
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: begin
								if (last_bit)
									ok_reg <= ~sda_s;
								else
									rx_reg <= {rx_reg[6:0], sda_s};
							end
							default: begin
								scl_oe_reg <= 1'b1;
								tx_reg <= {tx_reg[6:0], 1'b1};
								bit_reg <= 4'(bit_reg + 4'h1);
								if (last_bit) begin
									bit_reg <= 4'h0;
									step_reg <= restart ? 3'h3 : step_inc;
									tx_reg <= restart ? {chi_pkg::SLAVE_ADDR, 1'b1} : tx_sel;
									if (step_reg == 3'h4)
										ok_reg <= 1'b1;
									if (go_stop)
										state_reg <= chi_pkg::HS_STOP;
									else if (restart)
										state_reg <= chi_pkg::HS_START;
								end
							end
						endcase
					end
				end
				chi_pkg::HS_STOP: begin
					if (tick) begin
						ph_reg <= 2'(ph_reg + 2'h1);
						case (ph_reg)
							2'h0: sda_oe_reg <= 1'b1;
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: sda_oe_reg <= 1'b0;
							default: begin
								state_reg <= chi_pkg::HS_IDLE;
								cmd_ready_out <= 1'b1;
								rsp_valid_out <= 1'b1;
								rsp_ack_out <= ok_reg;
								rsp_data_out <= rx_reg;
							end
						endcase
					end
				end
				default: begin
					state_reg <= chi_pkg::HS_IDLE;
				end
			endcase
		end
	end

	assign link.scl_host_out = 1'b0;
	assign link.scl_host_oe = scl_oe_reg;
	assign link.sda_host_out = 1'b0;
	assign link.sda_host_oe = sda_oe_reg;
endmodule : chi_host
`default_nettype wire

// ### tb/chi_link_chk.sv
`timescale 1ns/1ns
`default_nettype none
module chi_link_chk (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic scl_host_out,
	input wire logic scl_host_oe,
	input wire logic sda_host_out,
	input wire logic sda_host_oe,
	input wire logic scl_dev_oe,
	input wire logic sda_dev_out,
	input wire logic sda_dev_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!nrst_in);
	// ****************
	// SCL rise spacing
	// ****************
	logic scl_reg;
	logic [7:0] gap_reg;
	wire logic scl_rise;
	assign scl_rise = scl & ~scl_reg;
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			scl_reg <= 1'b1;
			gap_reg <= 8'hff;
		end else begin
			scl_reg <= scl;
			gap_reg <= scl_rise ? 8'h00 : gap_reg + {7'h00, gap_reg != 8'hff};
		end
	end
	// ****************
	// Wire rules
	// ****************
	a_scl_host_od: assert property (scl_host_oe |-> !scl_host_out)
		else $error("host scl driven high");
	a_sda_host_od: assert property (sda_host_oe |-> !sda_host_out)
		else $error("host sda driven high");
	a_sda_dev_od: assert property (sda_dev_oe |-> !sda_dev_out)
		else $error("device sda driven high");
	a_no_stretch: assert property (!scl_dev_oe)
		else $error("device holds scl");
	a_dev_take_low: assert property ($rose(sda_dev_oe) |-> !scl)
		else $error("device took sda with scl high");
	a_dev_drop_low: assert property ($fell(sda_dev_oe) |-> !scl)
		else $error("device freed sda with scl high");
	a_scl_rate: assert property (scl_rise |-> gap_reg >= 8'h31)
		else $error("scl faster than fast mode");
	a_scl_high_min: assert property (scl_rise |-> scl[*8])
		else $error("scl high phase too short");
	a_start_hold: assert property (($fell(sda) && scl) |-> scl[*4])
		else $error("scl fell right after start");
	a_stop_free: assert property (($rose(sda) && scl) |=> (sda && scl)[*8])
		else $error("bus not free after stop");
	c_start: cover property ($fell(sda) && scl);
	c_dev_ack: cover property ($rose(sda_dev_oe));
	c_stop: cover property ($rose(sda) && scl);
endmodule : chi_link_chk
`default_nettype wire

// ### tb/chi_tb.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam int IPC = 20;
	logic sys_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [17:0] ev = '0;
	logic [2:0] therm = 3'h0;
	logic cv = 1'b0;
	logic crd = 1'b0;
	logic [7:0] cp = 8'h00;
	logic [7:0] cw = 8'h00;
	wire cr, rv, ra, inl, sw, ce, br, bs, cu, te, th;
	wire [7:0] rd;
	int n_fail = 0;
	int checks = 0;
	int n_int = 0;
	int run = 0;
	int len = 0;
	int k;
	int inj;
	int kt [4] = '{7, 12, 17, 13};
	logic [7:0] ft [4] = '{8'h10, 8'h20, 8'h30, 8'h08};
	logic a;
	logic [7:0] d;
	logic [7:0] v;
	logic [7:0] m [0:11];
	chi_link_if link ();
	chi_device #(.INT_PULSE_CYCLES(IPC)) chi_device_inst (.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in), .link(link), .src_ident_in(ev[0]), .good_src_in(ev[1]),
		.src_removed_in(ev[2]), .chg_done_in(ev[3]), .src_plug_in(ev[4]),
		.input_voltage_limit_loop_in(ev[5]), .input_current_limit_loop_in(ev[6]),
		.input_overvoltage_event_in(ev[7]), .system_overvoltage_event_in(ev[8]),
		.boost_short_in(ev[9]), .boost_ov_in(ev[10]), .temp_reg_in(ev[11]),
		.temp_shut_in(ev[12]), .battery_overvoltage_event_in(ev[13]),
		.batt_depleted_in(ev[14]), .batt_oc_in(ev[15]), .ship_exit_in(ev[16]),
		.timer_expired_in(ev[17]), .thermistor_fault_field_in(therm), .int_n_out(inl),
		.switching_en_out(sw), .charge_en_out(ce), .boost_run_out(br),
		.battery_switch_on_out(bs), .current_reduce_out(cu), .term_en_out(te),
		.timer_half_rate_out(th));
	chi_host chi_host_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .link(link),
		.cmd_valid_in(cv), .cmd_read_in(crd), .cmd_ptr_in(cp), .cmd_wdata_in(cw),
		.cmd_ready_out(cr), .rsp_valid_out(rv), .rsp_ack_out(ra), .rsp_data_out(rd));
	chi_link_chk chi_link_chk_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.scl_host_out(link.scl_host_out), .scl_host_oe(link.scl_host_oe),
		.sda_host_out(link.sda_host_out), .sda_host_oe(link.sda_host_oe),
		.scl_dev_oe(link.scl_dev_oe), .sda_dev_out(link.sda_dev_out),
		.sda_dev_oe(link.sda_dev_oe), .scl(link.scl), .sda(link.sda));
	initial begin
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	// ****************
	// Interrupt pulse monitor
	// ****************
	always @(posedge sys_clk_in) begin
		if (inl === 1'b0) begin
			run <= run + 1;
		end else if (run != 0) begin
			len <= run;
			n_int <= n_int + 1;
			run <= 0;
		end
	end
	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic r, input logic [7:0] p, input logic [7:0] w);
		int i;
		while (cr !== 1'b1) @(posedge sys_clk_in);
		cv <= 1'b1;
		crd <= r;
		cp <= p;
		cw <= w;
		@(posedge sys_clk_in);
		cv <= 1'b0;
		i = 0;
		while (rv !== 1'b1 && i < 9000) begin
			@(posedge sys_clk_in);
			i++;
		end
		if (i >= 9000) n_fail++;
		a = ra;
		d = rd;
	endtask : xfer
	task automatic wr(input logic [7:0] p, input logic [7:0] w);
		xfer(1'b0, p, w);
		chk(a, 1'b1);
		m[p] = w;
	endtask : wr
	task automatic rdc(input logic [7:0] p, input logic [7:0] exp);
		xfer(1'b1, p, 8'h00);
		chk(a, 1'b1);
		chk(d, exp);
	endtask : rdc
	task automatic intc(input int want);
		int n0;
		n0 = n_int;
		repeat (IPC + 20) @(posedge sys_clk_in);
		chk(8'(n_int - n0), 8'(want));
		if (want > 0) chk(8'(len), 8'(IPC));
	endtask : intc
	task automatic pulse(input int b);
		ev <= ev | (18'h1 << b);
		@(posedge sys_clk_in);
		ev <= ev & ~(18'h1 << b);
		repeat (3) @(posedge sys_clk_in);
	endtask : pulse
	task automatic wrap_up;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (100000) @(posedge sys_clk_in);
		n_fail++;
		wrap_up();
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		void'($urandom(15154));
		for (int i = 0; i < 12; i++) m[i] = chi_pkg::REG_RST[i];
		repeat (8) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		for (int i = 0; i < 12; i++) rdc(8'(i), m[i]);
		v = 8'($urandom);
		wr(8'h03, v);
		rdc(8'h03, m[3]);
		xfer(1'b1, 8'h0c, 8'h00);
		chk(a, 1'b0);
		for (int i = 0; i < 4; i++) begin
			pulse(i);
			intc(1);
		end
		wr(8'h0a, 8'h02);
		ev[6:5] <= 2'h1;
		intc(0);
		ev[6:5] <= 2'h3;
		intc(1);
		ev[6:5] <= 2'h0;
		for (int j = 0; j < 4; j++) begin
			k = kt[j];
			inj = (k == 13) ? 7 : 13;
			ev[k] <= 1'b1;
			intc(1);
			chk(ce, 8'(j == 2));
			chk(sw, 8'(j > 1));
			ev[k] <= 1'b0;
			ev[inj] <= 1'b1;
			intc(0);
			ev[inj] <= 1'b0;
			chk(bs, 1'b1);
			rdc(8'h09, ft[j]);
			rdc(8'h09, 8'h00);
		end
		wr(8'h01, m[1] | 8'h20);
		chk(br, 1'b1);
		repeat (7) pulse(9);
		intc(0);
		chk(br, 1'b1);
		pulse(9);
		intc(1);
		chk(br, 1'b0);
		rdc(8'h01, m[1] & 8'hdf);
		rdc(8'h09, 8'h40);
		ev[11] <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		chk({cu, te, th}, 3'h5);
		rdc(8'h08, 8'h02);
		ev[11] <= 1'b0;
		for (int j = 0; j < 2; j++) begin
			pulse(14 + j);
			chk(bs, 1'b0);
			pulse(j ? 4 : 16);
			chk(bs, 1'b0);
			pulse(j ? 16 : 4);
			chk(bs, 1'b1);
		end
		// Re-enabling boost clears the boost fault; the latch shows it once more
		wr(8'h01, m[1] | 8'h20);
		chk(br, 1'b1);
		rdc(8'h09, 8'h40);
		rdc(8'h09, 8'h00);
		therm <= 3'($urandom);
		@(posedge sys_clk_in);
		rdc(8'h09, {5'h00, therm});
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
